// file: verilog/uart_core.sv
// byte uart with modem pins, clock output and avalon register slave
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/100ps
module uart_core #(
   parameter int DIV_W = uart_pkg::DIV_W
) (
   input logic clk_i,
   input logic resetn_i,
   input logic chip_select_n_i,
   input logic [uart_pkg::ADDR_W-1:0] avs_address_i,
   input logic avs_read_i,
   input logic avs_write_i,
   input logic [3:0] avs_byteenable_i,
   input logic [uart_pkg::DATA_W-1:0] avs_writedata_i,
   output logic [uart_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input logic cts_n_i,
   input logic dsr_n_i,
   input logic serial_in_i,
   output logic serial_out_o,
   output logic dtr_n_o,
   output logic rts_n_o,
   output logic tx_holding_empty_o,
   output logic data_ready_o,
   output logic irq_out_o,
   output logic clock_out_pin_o
);
   uart_pkg::uart_state_t st;
   uart_pkg::uart_state_t next_st;
   logic req;
   logic accept;
   logic wr;
   logic rd;
   logic tx_line;
   logic rx_line;
   logic rx_done;
   logic tx_end;
   logic rx_end;
   logic cts_true;
   logic tick16;
   logic clk16;
   logic [3:0] char_bits;
   logic [7:0] rx_word;
   logic [uart_pkg::REG_W-1:0] wr_byte;

   assign wr_byte = avs_writedata_i[uart_pkg::REG_W-1:0];
   logic baud_run_n;
   // divisor bits survive reset, so a new select must restart the divider from a known count
   assign baud_run_n = resetn_i & ~(wr && avs_address_i == uart_pkg::OFS_BAUD_SELECT);

   uart_baud_gen #(
      .DIV_W(DIV_W)
   ) u_baud (
      .clk_i(clk_i),
      .resetn_i(baud_run_n),
      .prescale_sel_i(st.baud_sel[uart_pkg::BAUD_DIV_LSB-1:0]),
      .divisor_i(st.baud_sel[uart_pkg::BAUD_DIV_LSB+DIV_W-1:uart_pkg::BAUD_DIV_LSB]),
      .tick16_o(tick16),
      .clk16_o(clk16)
   );

   always_comb begin
      next_st = st;
      rx_done = 1'b0;
      rx_word = st.rx_shift;
      char_bits = {2'h0, st.lfr.char_len} + uart_pkg::CHAR_MIN;
      // pins pass two flops; only the second is ever looked at
      next_st.cts_sync = {st.cts_sync[0], cts_n_i};
      next_st.dsr_sync = {st.dsr_sync[0], dsr_n_i};
      next_st.sin_sync = {st.sin_sync[0], serial_in_i};
      next_st.cts_last = st.cts_sync[1];
      next_st.dsr_last = st.dsr_sync[1];
      cts_true = ~st.cts_sync[1];

      // bus slave: one wait cycle, effects at the edge waitrequest is low
      req = avs_read_i | avs_write_i;
      accept = req & ~st.bus_wait & ~chip_select_n_i;
      wr = accept & avs_write_i & avs_byteenable_i[0];
      rd = accept & avs_read_i;
      next_st.bus_wait = ~(req & st.bus_wait);
      if (req & st.bus_wait) begin
         if (chip_select_n_i) begin
            next_st.rdata = '0;
         end else begin
            case (avs_address_i)
               uart_pkg::OFS_DATA: next_st.rdata = uart_pkg::zext(st.rx_hold);
               uart_pkg::OFS_LINE_FORMAT: next_st.rdata = uart_pkg::zext(st.lfr);
               uart_pkg::OFS_BAUD_SELECT: next_st.rdata = uart_pkg::zext(st.baud_sel);
               uart_pkg::OFS_MODEM_CTRL: next_st.rdata = uart_pkg::zext(st.modem_control_reg);
               uart_pkg::OFS_UART_STATUS: next_st.rdata = uart_pkg::zext(st.uart_status_reg);
               uart_pkg::OFS_MODEM_STATUS: next_st.rdata = uart_pkg::zext(st.modem_status_reg);
               default: next_st.rdata = '0;
            endcase
         end
      end

      // read clears go first so a same-cycle hardware set wins
      if (rd && avs_address_i == uart_pkg::OFS_DATA) begin
         next_st.uart_status_reg.data_ready = 1'b0;
      end
      if (rd && avs_address_i == uart_pkg::OFS_UART_STATUS) begin
         next_st.uart_status_reg.overrun = 1'b0;
         next_st.uart_status_reg.framing_error = 1'b0;
         next_st.uart_status_reg.break_seen = 1'b0;
      end
      if (rd && avs_address_i == uart_pkg::OFS_MODEM_STATUS) begin
         next_st.modem_status_reg.cts_changed = 1'b0;
         next_st.modem_status_reg.dsr_changed = 1'b0;
      end

      // dsr only reaches its status bits and the change flag
      next_st.modem_status_reg.cts = cts_true;
      next_st.modem_status_reg.dsr = ~st.dsr_sync[1];
      if (st.cts_sync[1] != st.cts_last) begin
         next_st.modem_status_reg.cts_changed = 1'b1;
      end
      if (st.dsr_sync[1] != st.dsr_last) begin
         next_st.modem_status_reg.dsr_changed = 1'b1;
      end

      // transmitter
      tx_line = 1'b1;
      tx_end = tick16 && st.tx_sub == uart_pkg::SAMPLE_LAST;
      if (st.tx_st != uart_pkg::TX_IDLE && tick16) begin
         next_st.tx_sub = st.tx_sub + 4'h1;
      end
      case (st.tx_st)
         uart_pkg::TX_IDLE: begin
            // echo mode bypasses the transmitter entirely
            if (!st.uart_status_reg.tx_holding_empty && cts_true
                  && st.modem_control_reg.mode != uart_pkg::MODE_ECHO) begin
               next_st.tx_shift = st.tx_hold;
               next_st.uart_status_reg.tx_holding_empty = 1'b1;
               next_st.tx_st = uart_pkg::TX_START;
               next_st.tx_sub = 4'h0;
               next_st.tx_bits = 4'h0;
            end
         end
         uart_pkg::TX_START: begin
            tx_line = 1'b0;
            if (tx_end) begin
               next_st.tx_st = uart_pkg::TX_DATA;
            end
         end
         uart_pkg::TX_DATA: begin
            tx_line = st.tx_shift[0];
            if (tx_end) begin
               next_st.tx_shift = st.tx_shift >> 1;
               next_st.tx_bits = st.tx_bits + 4'h1;
               if (st.tx_bits == char_bits - 4'h1) begin
                  next_st.tx_st = uart_pkg::TX_STOP;
                  next_st.tx_stop2 = st.lfr.two_stop;
               end
            end
         end
         uart_pkg::TX_STOP: begin
            // a started character always runs to its stop bit
            if (tx_end) begin
               if (st.tx_stop2) begin
                  next_st.tx_stop2 = 1'b0;
               end else begin
                  next_st.tx_st = uart_pkg::TX_IDLE;
               end
            end
         end
         default: next_st.tx_st = uart_pkg::TX_IDLE;
      endcase

      // receiver: loop feeds it from the transmitter, pin ignored
      if (st.modem_control_reg.mode == uart_pkg::MODE_LOOP) begin
         rx_line = tx_line;
      end else begin
         rx_line = st.sin_sync[1];
      end
      rx_end = tick16 && st.rx_sub == uart_pkg::SAMPLE_LAST;
      if (st.rx_st != uart_pkg::RX_IDLE && tick16) begin
         next_st.rx_sub = st.rx_sub + 4'h1;
      end
      case (st.rx_st)
         uart_pkg::RX_IDLE: begin
            if (st.modem_control_reg.rx_enable && !rx_line) begin
               next_st.rx_st = uart_pkg::RX_START;
               next_st.rx_sub = 4'h0;
            end
         end
         uart_pkg::RX_START: begin
            // recheck mid start bit to reject glitches
            if (tick16 && st.rx_sub == uart_pkg::SAMPLE_MID) begin
               next_st.rx_sub = 4'h0;
               next_st.rx_bits = 4'h0;
               next_st.rx_st = rx_line ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
            end
         end
         uart_pkg::RX_DATA: begin
            if (rx_end) begin
               next_st.rx_shift = {rx_line, st.rx_shift[7:1]};
               next_st.rx_bits = st.rx_bits + 4'h1;
               if (st.rx_bits == char_bits - 4'h1) begin
                  next_st.rx_st = uart_pkg::RX_STOP;
               end
            end
         end
         uart_pkg::RX_STOP: begin
            if (rx_end) begin
               rx_done = 1'b1;
               rx_word = st.rx_shift >> (uart_pkg::CHAR_MAX - char_bits);
               next_st.rx_hold = rx_word;
               next_st.uart_status_reg.overrun = st.uart_status_reg.data_ready | next_st.uart_status_reg.overrun;
               next_st.uart_status_reg.data_ready = 1'b1;
               if (!rx_line) begin
                  next_st.uart_status_reg.framing_error = 1'b1;
                  next_st.uart_status_reg.break_seen = (st.rx_shift == 8'h00) | st.uart_status_reg.break_seen;
               end
               next_st.rx_st = uart_pkg::RX_IDLE;
            end
         end
         default: next_st.rx_st = uart_pkg::RX_IDLE;
      endcase
      if (!st.modem_control_reg.rx_enable) begin
         next_st.rx_st = uart_pkg::RX_IDLE;
      end

      // register writes
      if (wr) begin
         case (avs_address_i)
            uart_pkg::OFS_DATA: begin
               next_st.tx_hold = wr_byte;
               next_st.uart_status_reg.tx_holding_empty = 1'b0;
            end
            uart_pkg::OFS_LINE_FORMAT: next_st.lfr = wr_byte;
            uart_pkg::OFS_BAUD_SELECT: next_st.baud_sel = wr_byte;
            uart_pkg::OFS_MODEM_CTRL: begin
               next_st.modem_control_reg = wr_byte;
               next_st.modem_control_reg.rsvd = 1'b0;
            end
            default: next_st.bus_wait = next_st.bus_wait;
         endcase
      end
      next_st.uart_status_reg.transmission_complete = next_st.uart_status_reg.tx_holding_empty
         && next_st.tx_st == uart_pkg::TX_IDLE;

      // pins
      next_st.dtr_n = ~next_st.modem_control_reg.dtr;
      next_st.rts_n = ~next_st.modem_control_reg.rts;
      next_st.irq = next_st.modem_control_reg.irq_master_enable
         & ((next_st.modem_control_reg.modem_change_irq_enable
         & (next_st.modem_status_reg.cts_changed | next_st.modem_status_reg.dsr_changed))
         | next_st.uart_status_reg.data_ready);
      case (st.modem_control_reg.mode)
         uart_pkg::MODE_ECHO: next_st.sout = st.sin_sync[1];
         uart_pkg::MODE_LOOP: next_st.sout = 1'b1;
         uart_pkg::MODE_BREAK: next_st.sout = (st.tx_st == uart_pkg::TX_IDLE);
         default: next_st.sout = tx_line;
      endcase
      // oscillator can only be shown as a half-rate square from a flop
      if (st.baud_sel[uart_pkg::BAUD_CO_SEL_BIT]) begin
         next_st.clock_out = clk16;
      end else begin
         next_st.clock_out = ~st.clock_out;
      end

      // line format and low baud select bits survive reset
      if (!resetn_i) begin
         next_st.baud_sel[uart_pkg::BAUD_CO_SEL_BIT] = 1'b0;
         next_st.modem_control_reg = '0;
         next_st.uart_status_reg = '0;
         next_st.uart_status_reg.tx_holding_empty = 1'b1;
         next_st.uart_status_reg.transmission_complete = 1'b1;
         next_st.modem_status_reg.cts_changed = 1'b0;
         next_st.modem_status_reg.dsr_changed = 1'b0;
         next_st.tx_st = uart_pkg::TX_IDLE;
         next_st.rx_st = uart_pkg::RX_IDLE;
         next_st.tx_sub = 4'h0;
         next_st.rx_sub = 4'h0;
         next_st.tx_bits = 4'h0;
         next_st.rx_bits = 4'h0;
         next_st.tx_stop2 = 1'b0;
         next_st.tx_hold = 8'h00;
         next_st.rx_hold = 8'h00;
         next_st.bus_wait = 1'b1;
         next_st.rdata = '0;
         next_st.sout = 1'b1;
         next_st.dtr_n = 1'b1;
         next_st.rts_n = 1'b1;
         next_st.irq = 1'b0;
         next_st.clock_out = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      st <= next_st;
   end

   assign avs_readdata_o = st.rdata;
   assign avs_waitrequest_o = st.bus_wait;
   assign serial_out_o = st.sout;
   assign dtr_n_o = st.dtr_n;
   assign rts_n_o = st.rts_n;
   assign tx_holding_empty_o = st.uart_status_reg.tx_holding_empty;
   assign data_ready_o = st.uart_status_reg.data_ready;
   assign irq_out_o = st.irq;
   assign clock_out_pin_o = st.clock_out;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   property p_dsr_irq;
      (st.dsr_sync[1] != st.dsr_last) && st.modem_control_reg.irq_master_enable
         && st.modem_control_reg.modem_change_irq_enable && !wr |=> irq_out_o;
   endproperty
   a_dsr_irq: assert property (p_dsr_irq) else $error("dsr change gave no irq");

   property p_irq_gate;
      irq_out_o |-> st.modem_control_reg.irq_master_enable;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

   property p_dtr_write;
      wr && avs_address_i == uart_pkg::OFS_MODEM_CTRL |=> dtr_n_o != $past(wr_byte[0]);
   endproperty
   a_dtr_write: assert property (p_dtr_write) else $error("dtr not per write");

   property p_rts_write;
      wr && avs_address_i == uart_pkg::OFS_MODEM_CTRL |=> rts_n_o != $past(wr_byte[1]);
   endproperty
   a_rts_write: assert property (p_rts_write) else $error("rts not per write");

   property p_osc_out;
      resetn_i && !st.baud_sel[uart_pkg::BAUD_CO_SEL_BIT]
         ##1 !st.baud_sel[uart_pkg::BAUD_CO_SEL_BIT]
         |-> clock_out_pin_o != $past(clock_out_pin_o);
   endproperty
   a_osc_out: assert property (p_osc_out) else $error("clock out not oscillator");

   property p_tx_holding_empty_set;
      st.tx_st == uart_pkg::TX_IDLE && !st.uart_status_reg.tx_holding_empty && cts_true
         && st.modem_control_reg.mode != uart_pkg::MODE_ECHO && !wr
         |=> tx_holding_empty_o && st.tx_st == uart_pkg::TX_START;
   endproperty
   a_tx_holding_empty_set: assert property (p_tx_holding_empty_set) else $error("holding not moved");

   property p_tx_holding_empty_clr;
      wr && avs_address_i == uart_pkg::OFS_DATA |=> !tx_holding_empty_o;
   endproperty
   a_tx_holding_empty_clr: assert property (p_tx_holding_empty_clr) else $error("empty flag not cleared");

   property p_dr_clr;
      rd && avs_address_i == uart_pkg::OFS_DATA && !rx_done |=> !data_ready_o;
   endproperty
   a_dr_clr: assert property (p_dr_clr) else $error("data ready not cleared");

   property p_cts_block;
      st.tx_st == uart_pkg::TX_IDLE && !cts_true |=> st.tx_st == uart_pkg::TX_IDLE;
   endproperty
   a_cts_block: assert property (p_cts_block) else $error("sent without cts");

   property p_loop_mark;
      st.modem_control_reg.mode == uart_pkg::MODE_LOOP |=> serial_out_o;
   endproperty
   a_loop_mark: assert property (p_loop_mark) else $error("loop output not mark");

   property p_after_reset;
      $rose(resetn_i) |-> dtr_n_o && rts_n_o && tx_holding_empty_o && !data_ready_o
         && serial_out_o && !irq_out_o && st.uart_status_reg.transmission_complete;
   endproperty
   a_after_reset: assert property (p_after_reset) else $error("bad reset state");

   property p_bus_answer;
      req && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("no bus answer");

   c_irq: cover property (irq_out_o);
   c_rx_done: cover property (rx_done);
   c_tx_done: cover property ($rose(st.uart_status_reg.transmission_complete));
   c_read: cover property (rd && avs_address_i == uart_pkg::OFS_DATA);
endmodule : uart_core

// file: pkg/uart_pkg.sv
// shared constants, register layouts and state types of the uart block
package uart_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 5;
   localparam int REG_W = 8;
   localparam int DIV_W = 5;
   localparam logic [4:0] OFS_DATA = 5'h00;
   localparam logic [4:0] OFS_LINE_FORMAT = 5'h04;
   localparam logic [4:0] OFS_BAUD_SELECT = 5'h08;
   localparam logic [4:0] OFS_MODEM_CTRL = 5'h0C;
   localparam logic [4:0] OFS_UART_STATUS = 5'h10;
   localparam logic [4:0] OFS_MODEM_STATUS = 5'h14;
   localparam int BAUD_CO_SEL_BIT = 7;
   localparam int BAUD_DIV_LSB = 2;
   localparam logic [3:0] SAMPLE_LAST = 4'hF;
   localparam logic [3:0] SAMPLE_MID = 4'h7;
   localparam logic [3:0] CHAR_MIN = 4'h5;
   localparam logic [3:0] CHAR_MAX = 4'h8;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'h0,
      MODE_BREAK = 2'h1,
      MODE_ECHO = 2'h2,
      MODE_LOOP = 2'h3
   } op_mode_t;

   typedef struct packed {
      logic rsvd;
      logic rx_enable;
      op_mode_t mode;
      logic modem_change_irq_enable;
      logic irq_master_enable;
      logic rts;
      logic dtr;
   } modem_ctrl_t;

   typedef struct packed {
      logic [1:0] rsvd;
      logic transmission_complete;
      logic tx_holding_empty;
      logic data_ready;
      logic overrun;
      logic framing_error;
      logic break_seen;
   } uart_status_t;

   typedef struct packed {
      logic [3:0] rsvd;
      logic dsr_changed;
      logic cts_changed;
      logic dsr;
      logic cts;
   } modem_status_t;

   typedef struct packed {
      logic [4:0] rsvd;
      logic two_stop;
      logic [1:0] char_len;
   } line_format_t;

   typedef enum logic [3:0] {
      TX_IDLE = 4'h1,
      TX_START = 4'h2,
      TX_DATA = 4'h4,
      TX_STOP = 4'h8
   } tx_state_t;

   typedef enum logic [3:0] {
      RX_IDLE = 4'h1,
      RX_START = 4'h2,
      RX_DATA = 4'h4,
      RX_STOP = 4'h8
   } rx_state_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
      logic clk16;
   } baud_state_t;

   typedef struct packed {
      logic [1:0] cts_sync;
      logic [1:0] dsr_sync;
      logic [1:0] sin_sync;
      logic cts_last;
      logic dsr_last;
      modem_ctrl_t modem_control_reg;
      line_format_t lfr;
      logic [7:0] baud_sel;
      uart_status_t uart_status_reg;
      modem_status_t modem_status_reg;
      logic [7:0] tx_hold;
      tx_state_t tx_st;
      logic [7:0] tx_shift;
      logic [3:0] tx_sub;
      logic [3:0] tx_bits;
      logic tx_stop2;
      rx_state_t rx_st;
      logic [7:0] rx_shift;
      logic [3:0] rx_sub;
      logic [3:0] rx_bits;
      logic [7:0] rx_hold;
      logic bus_wait;
      logic [DATA_W-1:0] rdata;
      logic sout;
      logic dtr_n;
      logic rts_n;
      logic irq;
      logic clock_out;
   } uart_state_t;

   function automatic logic [2:0] prescale_ratio(input logic [1:0] sel);
      case (sel)
         2'h0: return 3'h1;
         2'h1: return 3'h3;
         2'h2: return 3'h4;
         default: return 3'h5;
      endcase
   endfunction : prescale_ratio

   function automatic logic [DATA_W-1:0] zext(input logic [REG_W-1:0] v);
      return {{(DATA_W-REG_W){1'b0}}, v};
   endfunction : zext
endpackage : uart_pkg

// file: verilog/uart_baud_gen.sv
// prescaler and divisor counter giving the 16x baud enable and clock
`timescale 1ns/100ps
module uart_baud_gen #(
   parameter int DIV_W = 5
) (
   input logic clk_i,
   input logic resetn_i,
   input logic [1:0] prescale_sel_i,
   input logic [DIV_W-1:0] divisor_i,
   output logic tick16_o,
   output logic clk16_o
);
   uart_pkg::baud_state_t st;
   uart_pkg::baud_state_t next_st;
   logic [7:0] total;
   logic [7:0] div_eff;

   always_comb begin
      next_st = st;
      // divisor zero selects the undivided prescaler output
      div_eff = (divisor_i == '0) ? 8'h01 : 8'(divisor_i);
      total = {5'h00, uart_pkg::prescale_ratio(prescale_sel_i)} * div_eff;
      next_st.tick = 1'b0;
      if (st.cnt == 8'h00) begin
         next_st.cnt = total - 8'h01;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt - 8'h01;
      end
      // roughly even duty; odd totals cannot be exact
      next_st.clk16 = (next_st.cnt >= (total >> 1));
      if (!resetn_i) begin
         next_st = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      st <= next_st;
   end

   assign tick16_o = st.tick;
   assign clk16_o = st.clk16;
endmodule : uart_baud_gen

// file: dv/host_bus_model.sv
// avalon master standing in for the host cpu
`timescale 1ns/100ps
module host_bus_model (
   input wire logic clk_i,
   input wire logic [31:0] rdata_i,
   input wire logic wait_i,
   output logic csn_o = 1'b1,
   output logic [4:0] addr_o = 5'h00,
   output logic rd_o = 1'b0,
   output logic wr_o = 1'b0,
   output logic [31:0] wdata_o = 32'h00000000
);
   // one access; held until waitrequest is seen low at an edge
   task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d,
         input logic csn, output logic [31:0] q);
      @(posedge clk_i);
      csn_o <= csn;
      addr_o <= a;
      wdata_o <= {24'h000000, d};
      rd_o <= !w;
      wr_o <= w;
      do @(posedge clk_i); while (wait_i !== 1'b0);
      q = rdata_i;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      csn_o <= 1'b1;
      // released data must not look valid
      wdata_o <= ~{24'h000000, d};
   endtask : xfer
endmodule : host_bus_model

// file: dv/test_uart_modem_pins_and_reset.sv
// self-checking bench for the uart core
`timescale 1ns/100ps
module test_uart_modem_pins_and_reset;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cts_n = 1'b0, dsr_n = 1'b1, sin = 1'b1;
   logic csn, rd, wr, so, dtr_n, rts_n, the, dr, irq, co, wt, b;
   logic [4:0] addr;
   logic [31:0] wdata, rdata, q;
   logic [9:0] fr;
   logic [7:0] ch;
   int fails = 0, n_compared = 0, cyc = 0, k;
   logic [7:0] rxq[$];
   always #2 clk_i = ~clk_i;
   uart_core uut (.clk_i(clk_i), .resetn_i(resetn_i), .chip_select_n_i(csn),
      .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_byteenable_i(4'h1), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wt), .cts_n_i(cts_n), .dsr_n_i(dsr_n),
      .serial_in_i(sin), .serial_out_o(so), .dtr_n_o(dtr_n), .rts_n_o(rts_n),
      .tx_holding_empty_o(the), .data_ready_o(dr), .irq_out_o(irq),
      .clock_out_pin_o(co));
   host_bus_model host (.clk_i(clk_i), .rdata_i(rdata), .wait_i(wt), .csn_o(csn),
      .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic w(input logic [4:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, 1'b0, q);
   endtask : w
   task automatic r(input logic [4:0] a);
      host.xfer(1'b0, a, 8'h00, 1'b0, q);
   endtask : r
   task automatic st(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : st
   task automatic do_reset;
      @(posedge clk_i);
      resetn_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      st(1);
   endtask : do_reset
   task automatic wait_dr;
      k = 0;
      while (dr !== 1'b1 && k < 400) begin
         st(1);
         k++;
      end
   endtask : wait_dr
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   // a hang ends the run as a failure
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         finish_test();
      end
   end
   initial begin
      void'($urandom(32'h072B));
      do_reset();
      chk("dtr_n", 1, dtr_n);
      chk("rts_n", 1, rts_n);
      chk("the", 1, the);
      chk("dr", 0, dr);
      chk("so", 1, so);
      r(uart_pkg::OFS_UART_STATUS);
      chk("usr", 32'h30, q);
      r(uart_pkg::OFS_MODEM_CTRL);
      chk("mcr", 0, q);
      r(uart_pkg::OFS_BAUD_SELECT);
      chk("cosel", 0, q[7]);
      r(uart_pkg::OFS_MODEM_STATUS);
      r(uart_pkg::OFS_MODEM_STATUS);
      chk("msr", 32'h01, q);
      st(1);
      b = co;
      st(1);
      chk("co", !b, co);
      $display("reset test done");
      for (k = 0; k < 4; k++) begin
         host.xfer(1'b1, uart_pkg::OFS_MODEM_CTRL, 8'h03 ^ k[7:0], 1'b1, q);
         w(uart_pkg::OFS_MODEM_CTRL, k[7:0]);
         #1;
         chk("dtr_n", !k[0], dtr_n);
         chk("rts_n", !k[1], rts_n);
      end
      host.xfer(1'b0, uart_pkg::OFS_MODEM_CTRL, 8'h00, 1'b1, q);
      chk("rd_cs", 0, q);
      $display("modem pin test done");
      w(uart_pkg::OFS_MODEM_CTRL, 8'h0C);
      dsr_n <= 1'b0;
      st(5);
      chk("irq", 1, irq);
      r(uart_pkg::OFS_MODEM_STATUS);
      chk("msr", 32'h0B, q);
      w(uart_pkg::OFS_MODEM_CTRL, 8'h08);
      dsr_n <= 1'b1;
      st(5);
      chk("irq", 0, irq);
      w(uart_pkg::OFS_MODEM_CTRL, 8'h04);
      st(2);
      chk("irq", 0, irq);
      r(uart_pkg::OFS_MODEM_STATUS);
      chk("msr", 32'h09, q);
      $display("irq test done");
      w(uart_pkg::OFS_LINE_FORMAT, 8'h03);
      w(uart_pkg::OFS_BAUD_SELECT, 8'h84);
      st(2);
      chk("co", 1, co);
      cts_n <= 1'b1;
      w(uart_pkg::OFS_MODEM_CTRL, 8'h40);
      ch = 8'($urandom);
      w(uart_pkg::OFS_DATA, ch);
      #1;
      chk("the", 0, the);
      st(40);
      chk("so", 1, so);
      chk("the", 0, the);
      cts_n <= 1'b0;
      k = 0;
      while (so !== 1'b0 && k < 60) begin
         st(1);
         k++;
      end
      st(8);
      chk("the", 1, the);
      fr = {1'b1, ch, 1'b0};
      for (k = 0; k < 10; k++) begin
         chk("so", fr[k], so);
         st(16);
      end
      st(20);
      chk("so", 1, so);
      $display("transmit test done");
      // garbage on the pin must not reach the receiver in loop mode
      w(uart_pkg::OFS_MODEM_CTRL, 8'h73);
      sin <= 1'b0;
      repeat (2) begin
         ch = 8'($urandom);
         rxq.push_back(ch);
         w(uart_pkg::OFS_DATA, ch);
         wait_dr();
         chk("dr", 1, dr);
         chk("so", 1, so);
         r(uart_pkg::OFS_DATA);
         chk("rx", rxq.pop_front(), q);
         #1;
         chk("dr", 0, dr);
      end
      $display("loop test done");
      // break drives space only while a character is busy
      w(uart_pkg::OFS_MODEM_CTRL, 8'h10);
      st(4);
      chk("so", 1, so);
      ch = 8'($urandom);
      w(uart_pkg::OFS_DATA, ch);
      st(4);
      chk("the", 1, the);
      chk("so", 0, so);
      // echo copies the pin level straight through
      w(uart_pkg::OFS_MODEM_CTRL, 8'h20);
      st(4);
      chk("so", 0, so);
      sin <= 1'b1;
      st(4);
      chk("so", 1, so);
      $display("mode test done");
      do_reset();
      chk("dr", 0, dr);
      chk("dtr_n", 1, dtr_n);
      chk("the", 1, the);
      r(uart_pkg::OFS_LINE_FORMAT);
      chk("lfr", 32'h03, q);
      r(uart_pkg::OFS_BAUD_SELECT);
      chk("brs", 32'h04, q);
      r(uart_pkg::OFS_UART_STATUS);
      chk("usr", 32'h30, q);
      $display("second reset test done");
      finish_test();
   end
endmodule : test_uart_modem_pins_and_reset
